/* dv/mpm_gen_props.sv */
/*
 checker for the pulse generator: error, sync and idle level relations.
 assumes it is bound onto mpm_generator and sees only its ports.
*/
`timescale 1ns/1ps
module mpm_gen_props #(
	parameter CW = 24
) (
	// clock, reset and control
	input wire i_clock,
	input wire i_rst_b,
	input wire i_mod_enable,
	input wire i_source_ext,
	input wire [1:0] i_pattern,
	input wire [2:0] i_trig_mode,
	input wire i_rf_on_high,
	input wire i_rate_is_freq,
	input wire i_step_enable,
	input wire [CW-1:0] i_period_ticks,
	input wire [CW-1:0] i_first_pulse_width,
	// outputs
	input wire o_mod_ctrl,
	input wire o_sync,
	input wire o_error
);
	// internal source in use
	wire intl = i_mod_enable && !i_source_ext;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	dis_level_a: assert property (
		!i_mod_enable |=> o_mod_ctrl == $past(i_rf_on_high)) else $error("idle level");
	sync_mode_a: assert property (
		$rose(o_sync) |-> $past(intl) && $past(i_trig_mode) < 3'h2) else $error("sync mode");
	err_mode_a: assert property (
		intl && i_trig_mode > 3'h5 |-> ##[1:20] o_error) else $error("bad mode");
	err_step_a: assert property (
		intl && i_step_enable && i_trig_mode != 3'h1 && i_trig_mode != 3'h3
		|-> ##[1:20] o_error) else $error("step mode");
	err_off_a: assert property (
		!intl [*2] |=> !o_error) else $error("error while off");
	guard_err_a: assert property (
		intl && i_trig_mode == 3'h0 && i_pattern == 2'h0 && !i_rate_is_freq &&
		i_period_ticks < i_first_pulse_width + 5 |-> ##[1:20] o_error) else $error("guard");
	sync_min_a: assert property (
		$rose(o_sync) && intl && i_trig_mode < 3'h2 |=> o_sync)
		else $error("short pulse");
	sync_rest_a: assert property (
		$fell(o_sync) && intl && i_trig_mode < 3'h2 |=> !o_sync)
		else $error("short gap");
	// main scenarios
	cover property ($rose(o_sync));
	cover property ($rose(o_error));
	cover property (i_trig_mode == 3'h2 && $rose(o_mod_ctrl));
endmodule // mpm_gen_props
bind mpm_generator mpm_gen_props #(.CW(CW)) u_props (.*);

/* dv/mpm_trig_src.sv */
/*
 external trigger source model: repeating pulse, either polarity.
 assumes the bench starts and stops it between measurements.
*/
`timescale 1ns/1ps
module mpm_trig_src (
	// clock, reset and control
	input wire i_clock,
	input wire i_rst_b,
	input wire i_run,
	input wire i_act_low,
	// trigger line
	output reg o_pulse
);
	reg [6:0] cnt_r;
	// 100 cycle period, 4 active: longer than period plus width
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 7'h00;
			o_pulse <= 1'b0;
		end else begin
			cnt_r <= (!i_run || cnt_r == 7'h63) ? 7'h00 : cnt_r + 7'h01;
			o_pulse <= i_act_low ^ (i_run && cnt_r < 7'h04);
		end
	end
endmodule // mpm_trig_src

/* dv/tb.sv */
/*
 testbench for mpm_generator: settings table, then pulse counts.
 assumes a 200 MHz clock and the trigger source model.
*/
`timescale 1ns/1ps
module tb;
	reg i_clock, i_rst_b, i_mod_enable, i_source_ext, i_trig_falling;
	reg i_rf_on_high, i_clock_slow, i_rate_is_freq, i_step_enable;
	reg p_run, p_low;
	reg [1:0] i_pattern;
	reg [2:0] i_trig_mode;
	reg [23:0] i_period_ticks, i_repetition_frequency, i_step_delay;
	reg [23:0] i_first_pulse_width, i_second_pulse_width;
	reg [23:0] i_third_pulse_width, i_fourth_pulse_width;
	reg [23:0] i_first_pulse_delay, i_second_pulse_delay;
	reg [23:0] i_third_pulse_delay, i_fourth_pulse_delay;
	wire i_ext_pulse, o_mod_ctrl, o_sync, o_error;
	integer miscompares = 0, samples_checked = 0, cyc = 0, cs, cm, k;
	// mode, pattern, step, error, period, first width
	reg [31:0] rows [0:11] = '{32'h0000_1402, 32'h0001_0602, 32'h0000_0702,
		32'h1010_1402, 32'h0011_1402, 32'h2000_1402, 32'h3010_1402,
		32'h4000_1402, 32'h5000_1402, 32'h6001_1402, 32'h7001_1402,
		32'h0300_1402};
	mpm_generator #(.CW(24)) dut_u (.*);
	mpm_trig_src src_u (.i_clock, .i_rst_b, .i_run(p_run), .i_act_low(p_low),
		.o_pulse(i_ext_pulse));
	// clock
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	task chk(input string nm, input integer e, input integer g);
		begin
			samples_checked = samples_checked + 1;
			if (e != g) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
			end
			$display("test %s ended", nm);
		end
	endtask
	// apply mode and flags {slow, freq, rf high, falling}, settle, count
	task setm(input [2:0] md, input [1:0] pt, input [3:0] fl, input integer n);
		begin
			@(posedge i_clock);
			i_trig_mode <= md;
			i_pattern <= pt;
			{i_clock_slow, i_rate_is_freq, i_rf_on_high, i_trig_falling} <= fl;
			p_run <= md[1] | md[2];
			p_low <= fl[0];
			repeat (n) @(posedge i_clock);
			{cs, cm} = 64'h0;
			repeat (n) begin
				@(posedge i_clock);
				#1;
				if (o_sync === 1'b1) cs = cs + 1;
				if (o_mod_ctrl === 1'b1) cm = cm + 1;
			end
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", samples_checked, miscompares);
			if (miscompares == 0 && samples_checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// hang guard
	always @(posedge i_clock) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			miscompares = miscompares + 1;
			summarize;
		end
	end
	// main sequence
	initial begin
		{i_rst_b, i_source_ext, i_trig_falling, i_clock_slow} = 4'h0;
		{i_rate_is_freq, i_step_enable, p_run, p_low} = 4'h0;
		{i_pattern, i_trig_mode, i_mod_enable, i_rf_on_high} = 7'h03;
		{i_third_pulse_delay, i_fourth_pulse_delay, i_step_delay} = 72'h0;
		{i_period_ticks, i_first_pulse_width} = 48'h000014_000002;
		{i_second_pulse_width, i_second_pulse_delay} = 48'h000003_000001;
		{i_third_pulse_width, i_fourth_pulse_width} = 48'h000001_000001;
		{i_first_pulse_delay, i_repetition_frequency} = 48'h000003_4C4B40;
		repeat (3) @(posedge i_clock);
		#1 chk("reset", 1, {o_mod_ctrl, o_sync, o_error} === 3'h0);
		@(posedge i_clock);
		i_rst_b <= 1'b1;
		for (k = 0; k < 12; k = k + 1) begin
			@(posedge i_clock);
			i_trig_mode <= rows[k][30:28];
			i_pattern <= rows[k][25:24];
			i_step_enable <= rows[k][20];
			i_period_ticks <= {16'h0000, rows[k][15:8]};
			i_first_pulse_width <= {16'h0000, rows[k][7:0]};
			repeat (4) @(posedge i_clock);
			#1 chk("error_row", 1, o_error === rows[k][16]);
		end
		setm(3'h0, 2'h0, 4'h2, 80);
		chk("free_sync", 8, cs);
		chk("free_ctrl", 8, cm);
		setm(3'h0, 2'h0, 4'h0, 80);
		chk("rf_low", 72, cm);
		setm(3'h0, 2'h0, 4'h6, 80);
		chk("freq_form", 8, cm);
		setm(3'h0, 2'h1, 4'h2, 80);
		chk("double", 20, cm);
		setm(3'h0, 2'h0, 4'hA, 400);
		chk("slow", 40, cm);
		setm(3'h2, 2'h0, 4'h2, 200);
		chk("trig_rise", 8, cm);
		chk("trig_nosync", 0, cs);
		setm(3'h2, 2'h0, 4'h3, 200);
		chk("trig_fall", 8, cm);
		setm(3'h4, 2'h1, 4'h2, 200);
		chk("gated_single", 8, cm);
		chk("gated_nosync", 0, cs);
		i_source_ext <= 1'b1;
		setm(3'h2, 2'h0, 4'h2, 200);
		chk("ext_source", 8, cm);
		chk("ext_nosync", 0, cs);
		@(posedge i_clock);
		i_source_ext <= 1'b0;
		i_mod_enable <= 1'b0;
		repeat (3) @(posedge i_clock);
		#1 chk("off_level", 1, o_mod_ctrl === i_rf_on_high);
		summarize;
	end
endmodule // tb

/* rtl/mpm_defs.vh */
/*
 multi-pulse modulation generator constants: modes, timebase, guard times.
 assumes inclusion by bare name from rtl/ design files.
*/
`ifndef MPM_DEFS_VH
`define MPM_DEFS_VH
// pulse patterns
`define MPM_PAT_SINGLE 2'h0
`define MPM_PAT_DOUBLE 2'h1
`define MPM_PAT_TRIPLE 2'h2
`define MPM_PAT_QUAD 2'h3
// trigger modes
`define MPM_TRG_FREE 3'h0
`define MPM_TRG_DELAYED 3'h1
`define MPM_TRG_EXT 3'h2
`define MPM_TRG_EXT_DLY 3'h3
`define MPM_TRG_GATED 3'h4
`define MPM_TRG_COMPOSITE 3'h5
// system clock and timebase rates in MHz
`define MPM_SYS_MHZ 200
`define MPM_FAST_MHZ 100
`define MPM_ALT_FAST_MHZ 40
`define MPM_SLOW_MHZ 10
// period guard times in ns
`define MPM_GUARD_FAST_NS 50
`define MPM_GUARD_ALT_NS 125
`define MPM_GUARD_SLOW_NS 500
`endif

/* rtl/mpm_generator.v */
/*
 multi-pulse modulation generator: one to four pulses per period, trigger,
 delay, gating and composite modes, sync out and settings check.
 assumes all inputs synchronous to i_clock and held steady by software.
*/
`timescale 1ns/1ps
`include "mpm_defs.vh"
module mpm_generator #(
	parameter CW = 24,
	parameter ALT_BUILD = 0
) (
	// clock and reset
	input wire i_clock,
	input wire i_rst_b,
	// control
	input wire i_mod_enable,
	input wire i_source_ext,
	input wire [1:0] i_pattern,
	input wire [2:0] i_trig_mode,
	input wire i_trig_falling,
	input wire i_rf_on_high,
	input wire i_clock_slow,
	input wire i_rate_is_freq,
	input wire [CW-1:0] i_period_ticks,
	input wire [CW-1:0] i_repetition_frequency,
	input wire i_step_enable,
	input wire [CW-1:0] i_step_delay,
	// pulse widths and delays in ticks
	input wire [CW-1:0] i_first_pulse_width,
	input wire [CW-1:0] i_second_pulse_width,
	input wire [CW-1:0] i_third_pulse_width,
	input wire [CW-1:0] i_fourth_pulse_width,
	input wire [CW-1:0] i_first_pulse_delay,
	input wire [CW-1:0] i_second_pulse_delay,
	input wire [CW-1:0] i_third_pulse_delay,
	input wire [CW-1:0] i_fourth_pulse_delay,
	// external pulse / trigger input
	input wire i_ext_pulse,
	// outputs
	output reg o_mod_ctrl,
	output reg o_sync,
	output reg o_error
);
	localparam [7:0] FAST_MHZ = ALT_BUILD ? `MPM_ALT_FAST_MHZ : `MPM_FAST_MHZ;
	localparam [7:0] SLOW_MHZ = `MPM_SLOW_MHZ;
	localparam [7:0] FAST_DIV = `MPM_SYS_MHZ / FAST_MHZ;
	localparam [7:0] SLOW_DIV = `MPM_SYS_MHZ / SLOW_MHZ;
	// guard ticks = ns * MHz / 1000, rounded up
	localparam [CW+1:0] G_FAST = ALT_BUILD ?
		(`MPM_GUARD_ALT_NS * `MPM_ALT_FAST_MHZ + 999) / 1000 :
		(`MPM_GUARD_FAST_NS * `MPM_FAST_MHZ + 999) / 1000;
	localparam [CW+1:0] G_SLOW =
		(`MPM_GUARD_SLOW_NS * `MPM_SLOW_MHZ + 999) / 1000;
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_DELAY = 3'h1;
	localparam [2:0] ST_WIDTH = 3'h2;
	localparam [2:0] ST_REST = 3'h3;

	reg [7:0] div_r;
	reg tick_r;
	reg ext_d_r;
	reg [2:0] st_r;
	reg [1:0] idx_r;
	reg [CW-1:0] cnt_r;
	reg [CW-1:0] per_r;
	reg pulse_r;
	reg gate_seen_r;
	wire [7:0] div_max;
	wire trig_edge;
	wire ext_act;
	wire free_mode;
	wire gated;
	wire use_d1;
	wire [1:0] last_idx;
	wire [CW-1:0] period;
	wire [CW-1:0] cur_w;
	wire [CW-1:0] cur_d;
	wire [CW+3:0] sum;
	wire [CW+3:0] guard;
	wire bad;
	wire waveform;
	// ticks per second of the chosen timebase, and the raw quotient
	wire [31:0] rate_hz;
	wire [CW+31:0] quo;

	// select per-pulse field by index
	function [CW-1:0] pick;
		input [1:0] i;
		input [CW-1:0] a;
		input [CW-1:0] b;
		input [CW-1:0] c;
		input [CW-1:0] d;
		begin
			case (i)
				2'h0: pick = a;
				2'h1: pick = b;
				2'h2: pick = c;
				default: pick = d;
			endcase
		end
	endfunction

	// true for the two modes in which the first delay is applied
	function delay_mode;
		input [2:0] m;
		begin
			delay_mode = (m == `MPM_TRG_DELAYED) || (m == `MPM_TRG_EXT_DLY);
		end
	endfunction

	// true for the internally timed modes that drive the sync output
	function sync_mode;
		input [2:0] m;
		begin
			sync_mode = (m == `MPM_TRG_FREE) || (m == `MPM_TRG_DELAYED);
		end
	endfunction

	// first delay source: stepped value only in delay modes
	// outside those modes the first delay reads as zero, so a stale
	// value left over from an earlier mode cannot shift the pattern
	assign use_d1 = delay_mode(i_trig_mode);
	assign gated = (i_trig_mode == `MPM_TRG_GATED);
	assign last_idx = gated ? 2'h0 : i_pattern;
	assign cur_w = pick(idx_r, i_first_pulse_width, i_second_pulse_width,
		i_third_pulse_width, i_fourth_pulse_width);
	assign cur_d = (idx_r == 2'h0) ?
		(use_d1 ? ((i_step_enable) ? i_step_delay : i_first_pulse_delay)
		: {CW{1'b0}})
		: pick(idx_r, i_first_pulse_delay, i_second_pulse_delay,
		i_third_pulse_delay, i_fourth_pulse_delay);

	// period from time or from frequency (ticks per second / frequency)
	// the division is wide so that no bits are lost before the cut;
	// a zero frequency gives the longest period instead of a divide fault
	assign rate_hz = (i_clock_slow ? {24'h000000, SLOW_MHZ} :
		{24'h000000, FAST_MHZ}) * 32'h000F4240;
	assign quo = {{CW{1'b0}}, rate_hz} /
		{32'h00000000, i_repetition_frequency};
	assign period = i_rate_is_freq ?
		((i_repetition_frequency == {CW{1'b0}}) ? {CW{1'b1}} :
		quo[CW-1:0]) : i_period_ticks;

	// timebase tick generator
	assign div_max = i_clock_slow ? SLOW_DIV : FAST_DIV;
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (div_r == div_max - 8'h01);
			div_r <= (div_r >= div_max - 8'h01) ? 8'h00 : div_r + 8'h01;
		end
	end

	// trigger edge selection
	assign trig_edge = i_trig_falling ? (ext_d_r & ~i_ext_pulse) :
		(~ext_d_r & i_ext_pulse);
	assign ext_act = i_trig_falling ? ~i_ext_pulse : i_ext_pulse;
	assign free_mode = (i_trig_mode == `MPM_TRG_FREE) ||
		(i_trig_mode == `MPM_TRG_DELAYED) ||
		(i_trig_mode == `MPM_TRG_COMPOSITE) ||
		(gated && ext_act);

	// pulse sequencer, counts in timebase ticks
	// idle waits for a start tick, delay counts the gap before a pulse,
	// width holds the pulse, rest fills the period up to its length.
	// the idle tick itself is the last tick of a period, so a free
	// running pattern repeats exactly every period ticks.
	// a trigger seen while busy is latched once and starts the next
	// period; further triggers in that time are dropped.
	// switching modulation off or to the external source parks the
	// sequencer so that it restarts cleanly from pulse one.
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_d_r <= 1'b0;
			st_r <= ST_IDLE;
			idx_r <= 2'h0;
			cnt_r <= {CW{1'b0}};
			per_r <= {CW{1'b0}};
			pulse_r <= 1'b0;
			gate_seen_r <= 1'b0;
		end else begin
			ext_d_r <= i_ext_pulse;
			gate_seen_r <= trig_edge ? 1'b1 : gate_seen_r;
			if (!i_mod_enable || i_source_ext) begin
				st_r <= ST_IDLE;
				pulse_r <= 1'b0;
				gate_seen_r <= 1'b0;
			end else begin
				case (st_r)
					ST_IDLE: begin
						if ((free_mode || gate_seen_r || trig_edge) && tick_r) begin
							st_r <= ST_DELAY;
							gate_seen_r <= 1'b0;
							idx_r <= 2'h0;
							cnt_r <= {CW{1'b0}};
							per_r <= {CW{1'b0}};
						end
					end
					ST_DELAY: if (tick_r) begin
						per_r <= per_r + 1'b1;
						if (cnt_r >= cur_d) begin
							st_r <= ST_WIDTH;
							pulse_r <= 1'b1;
							cnt_r <= {{(CW-1){1'b0}}, 1'b1};
						end else begin
							cnt_r <= cnt_r + 1'b1;
						end
					end
					ST_WIDTH: if (tick_r) begin
						per_r <= per_r + 1'b1;
						if (cnt_r >= cur_w) begin
							pulse_r <= 1'b0;
							cnt_r <= {{(CW-1){1'b0}}, 1'b1};
							if (idx_r == last_idx) begin
								st_r <= ST_REST;
							end else begin
								idx_r <= idx_r + 2'h1;
								st_r <= ST_DELAY;
							end
						end else begin
							cnt_r <= cnt_r + 1'b1;
						end
					end
					ST_REST: if (tick_r) begin
						per_r <= per_r + 1'b1;
						// the idle tick that follows is the period's last
						if ({1'b0, per_r} + {{(CW-1){1'b0}}, 2'h2} >=
							{1'b0, period})
							st_r <= ST_IDLE;
					end
					default: st_r <= ST_IDLE;
				endcase
			end
		end
	end

	// settings check: sum of widths and delays plus guard against period
	// the sum is four bits wider than a field so that four maximal
	// widths and delays cannot wrap and hide a bad setting
	assign sum = {4'h0, i_first_pulse_width} +
		(use_d1 ? {4'h0, i_first_pulse_delay} : {(CW+4){1'b0}}) +
		((last_idx >= 2'h1) ? {4'h0, i_second_pulse_width} +
		{4'h0, i_second_pulse_delay} : {(CW+4){1'b0}}) +
		((last_idx >= 2'h2) ? {4'h0, i_third_pulse_width} +
		{4'h0, i_third_pulse_delay} : {(CW+4){1'b0}}) +
		((last_idx == 2'h3) ? {4'h0, i_fourth_pulse_width} +
		{4'h0, i_fourth_pulse_delay} : {(CW+4){1'b0}});
	assign guard = {2'h0, (i_clock_slow ? G_SLOW : G_FAST)};
	assign bad = ({4'h0, period} < sum + guard) ||
		(i_trig_mode > `MPM_TRG_COMPOSITE) ||
		(i_step_enable && !use_d1);

	// external source select and composite sum
	assign waveform = i_source_ext ? i_ext_pulse :
		((i_trig_mode == `MPM_TRG_COMPOSITE) ? (pulse_r | i_ext_pulse)
		: pulse_r);

	// registered outputs
	// all three come from flip-flops so that the far side never sees
	// a glitch from the decode of mode and pattern inputs
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mod_ctrl <= 1'b0;
			o_sync <= 1'b0;
			o_error <= 1'b0;
		end else begin
			o_mod_ctrl <= i_mod_enable ? (waveform ~^ i_rf_on_high)
				: i_rf_on_high;
			o_sync <= pulse_r && !i_source_ext &&
				sync_mode(i_trig_mode);
			o_error <= i_mod_enable && !i_source_ext && bad;
		end
	end
endmodule // mpm_generator
